// File: src/eafc_top.sv
// Automatic flow control: register, threshold watch, pause requests and jam control.
// Assumes receive events, FIFO level and mode bits come from same-clock MAC logic.
`timescale 1ns/1ps
module eafc_top
  import eafc_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic [7:0]           reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [31:0]          reg_wdata,
  output logic      [31:0]          reg_rdata,
  input  wire logic [EAFC_FIFO_W:0] rx_fifo_bytes,
  input  wire logic                 full_duplex,
  input  wire logic                 speed_10m,
  input  wire logic                 tx_enabled,
  input  wire eafc_rxev_s           rx_ev,
  input  wire logic [15:0]          pause_time_value,
  output logic                      pause_req,
  output logic      [15:0]          pause_time,
  input  wire logic                 pause_ack,
  output logic                      jam_active
);
  //////////////////////////////////////////////////////////////////////////////
  // Configuration register.
  eafc_cfg_s cfg;
  wire logic cfg_sel = (reg_addr == EAFC_CFG_OFFSET);
  wire eafc_cfg_s next_cfg = eafc_cfg_s'(reg_wdata[23:0]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= eafc_cfg_s'(EAFC_CFG_RESET);
    end else if (clk_en && reg_wr && cfg_sel) begin
      cfg <= next_cfg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= cfg_sel ? {8'h00, cfg} : 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Threshold watch.
  wire logic hi_reached = (rx_fifo_bytes >= eafc_bytes(cfg.high_thr));
  wire logic lo_below   = (rx_fifo_bytes <  eafc_bytes(cfg.low_thr));
  wire logic fd_enable  = full_duplex && cfg.any_frame;
  wire logic hd_sel     = cfg.any_frame | cfg.jam_mcast | cfg.jam_bcast | cfg.jam_own;

  //////////////////////////////////////////////////////////////////////////////
  // Full-duplex pause requests.
  typedef enum logic [1:0] {
    EAFC_IDLE  = 2'b00,
    EAFC_SENDP = 2'b01,
    EAFC_WAITL = 2'b11,
    EAFC_SENDZ = 2'b10
  } eafc_state_e;

  eafc_state_e state;
  eafc_state_e next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      EAFC_IDLE:  if (fd_enable && tx_enabled && hi_reached) next_state = EAFC_SENDP;
      EAFC_SENDP: if (!tx_enabled) next_state = EAFC_IDLE;
                  else if (pause_ack) next_state = EAFC_WAITL;
      EAFC_WAITL: if (!fd_enable) next_state = EAFC_IDLE;
                  else if (lo_below && tx_enabled) next_state = EAFC_SENDZ;
      EAFC_SENDZ: if (!tx_enabled || !fd_enable) next_state = EAFC_IDLE;
                  else if (pause_ack) next_state = EAFC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= EAFC_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pause_time <= 16'h0000;
    end else if (clk_en) begin
      pause_time <= (next_state == EAFC_SENDZ) ? 16'h0000 : pause_time_value;
    end
  end

  assign pause_req = (state == EAFC_SENDP || state == EAFC_SENDZ) && tx_enabled;

  //////////////////////////////////////////////////////////////////////////////
  // Half-duplex jamming.
  wire logic frame_match = cfg.any_frame ? rx_ev.preamble :
                           rx_ev.start && ((cfg.jam_mcast && rx_ev.mcast) ||
                                           (cfg.jam_bcast && rx_ev.bcast) ||
                                           (cfg.jam_own   && rx_ev.own));
  wire logic jam_start = !full_duplex && tx_enabled && hi_reached && hd_sel
                         && frame_match;
  wire logic jam_busy;

  eafc_jam_timer u_jam (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .start    (jam_start),
    .cycles   (eafc_dur_cycles(cfg.dur_code, speed_10m)),
    .busy     (jam_busy)
  );

  assign jam_active = jam_busy && tx_enabled && !full_duplex;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_no_pause_txoff: assert property (@(posedge core_clk) disable iff (!rst_n)
    !tx_enabled |-> !pause_req && !jam_active) else $error("flow action with tx off");
  chk_txoff_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !tx_enabled && state != EAFC_WAITL |=> state == EAFC_IDLE)
    else $error("pause state kept with tx off");
  chk_one_pause_hi: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state == EAFC_SENDP && pause_ack && tx_enabled |=> state == EAFC_WAITL)
    else $error("timed pause not single");
  chk_zero_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == EAFC_SENDZ |-> pause_time == 16'h0000) else $error("zero pause time wrong");
  chk_zero_after_hi: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && $changed(state) && state == EAFC_SENDZ |-> $past(state) == EAFC_WAITL)
    else $error("zero pause without prior pause");
  chk_fd_needs_any: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state == EAFC_IDLE && !fd_enable |=> state == EAFC_IDLE)
    else $error("pause started without full-duplex enable");
  chk_fd_request: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state == EAFC_IDLE && fd_enable && tx_enabled && hi_reached
    |=> state == EAFC_SENDP) else $error("pause not requested");
  chk_hd_jam_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && jam_start |=> jam_busy) else $error("jam did not start");
  chk_fd_no_jam: assert property (@(posedge core_clk) disable iff (!rst_n)
    full_duplex |-> !jam_active) else $error("jam in full duplex");
  chk_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rdata[31:24] == 8'h00) else $error("reserved bits set");
  chk_cfg_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && reg_wr && cfg_sel |=> {8'h00, cfg} == ($past(reg_wdata) & 32'h00ffffff))
    else $error("config write lost");
  chk_threshold_cmp: assert property (@(posedge core_clk) disable iff (!rst_n)
    hi_reached == (rx_fifo_bytes[EAFC_FIFO_W:EAFC_UNIT_SHIFT] >= cfg.high_thr) &&
    lo_below == (rx_fifo_bytes[EAFC_FIFO_W:EAFC_UNIT_SHIFT] < cfg.low_thr))
    else $error("threshold compare wrong");

  cov_timed_pause: cover property (@(posedge core_clk) state == EAFC_SENDP && pause_ack);
  cov_zero_pause:  cover property (@(posedge core_clk) state == EAFC_SENDZ && pause_ack);
  cov_jam:         cover property (@(posedge core_clk) jam_start);
  cov_any_jam:     cover property (@(posedge core_clk) jam_start && cfg.any_frame);
endmodule // eafc_top

// File: src/eafc_pkg.sv
// Constants, field layout and carrier types for the automatic flow control block.
// Assumes a single 50 MHz core clock and a register port with its own address and strobes.
// How it works
// - No pause frame and no jam is started while the transmitter is disabled.
// - The high threshold sits in bits 23:16 in 64-byte units and reaching it arms flow control.
// - In full duplex reaching the high threshold requests exactly one timed pause frame.
// - In half duplex each matching incoming frame past the high threshold is jammed.
// - The low threshold sits in bits 15:8 and falling below it requests a zero-time pause.
// - A zero-time pause follows only a sent timed pause, and only while flow control is on.
// - The jam duration code in bits 7:4 sets the jam length and is unused in full duplex.
// - Jam on multicast, bit 3, jams multicast frames past the threshold in half duplex.
// - Jam on broadcast, bit 2, jams broadcast frames past the threshold in half duplex.
// - Jam on own address, bit 1, jams frames for this station past the threshold.
// - Flow on any frame, bit 0, enables full-duplex pause and overrides bits 3:1.
// - With bit 0 in half duplex the jam starts at the preamble of the next frame.
// - With bit 0 in full duplex the pause request is raised at once when the level is reached.
// - Jam code 0 lasts 5 us at 100 Mb/s and 7.2 us at 10 Mb/s, code F lasts 600 us at 100 Mb/s and 602.2 us at 10 Mb/s.
package eafc_pkg;
  localparam logic [7:0]  EAFC_CFG_OFFSET   = 8'hac;
  localparam int          EAFC_HI_LSB       = 16;
  localparam int          EAFC_LO_LSB       = 8;
  localparam int          EAFC_DUR_LSB      = 4;
  localparam int          EAFC_UNIT_SHIFT   = 6;
  localparam logic [23:0] EAFC_CFG_RESET    = 24'h000000;
  localparam int          EAFC_CLK_MHZ      = 50;
  localparam int          EAFC_EXTRA_10M_NS = 2200;
  localparam int          EAFC_FIFO_W       = 14;

  typedef struct packed {
    logic [7:0] high_thr;
    logic [7:0] low_thr;
    logic [3:0] dur_code;
    logic       jam_mcast;
    logic       jam_bcast;
    logic       jam_own;
    logic       any_frame;
  } eafc_cfg_s;

  typedef struct packed {
    logic start;
    logic preamble;
    logic mcast;
    logic bcast;
    logic own;
  } eafc_rxev_s;

  // Jam time in microseconds at 100 Mb/s for each duration code.
  function automatic int eafc_dur_us(input logic [3:0] code);
    case (code)
      4'h0: eafc_dur_us = 5;
      4'h1: eafc_dur_us = 10;
      4'h2: eafc_dur_us = 15;
      4'h3: eafc_dur_us = 25;
      default: eafc_dur_us = (int'(code) - 3) * 50;
    endcase
  endfunction

  // Jam length in core cycles, adding the fixed 2.2 us at 10 Mb/s.
  function automatic logic [15:0] eafc_dur_cycles(input logic [3:0] code, input logic slow);
    int c;
    c = eafc_dur_us(code) * EAFC_CLK_MHZ + (slow ? EAFC_EXTRA_10M_NS * EAFC_CLK_MHZ / 1000 : 0);
    eafc_dur_cycles = c[15:0];
  endfunction

  // Threshold field to bytes.
  function automatic logic [EAFC_FIFO_W:0] eafc_bytes(input logic [7:0] f);
    eafc_bytes = (EAFC_FIFO_W + 1)'({1'b0, f}) << EAFC_UNIT_SHIFT;
  endfunction
endpackage

// File: src/eafc_jam_timer.sv
// Back-pressure jam timer.
// Assumes the caller gives a start pulse and a cycle count; runs on core_clk.
`timescale 1ns/1ps
module eafc_jam_timer
  import eafc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic [15:0] cycles,
  output logic             busy
);
  logic [15:0] remain;
  wire  logic [15:0] next_remain = start ? cycles :
                                   (remain != 16'h0000 ? remain - 16'h0001 : 16'h0000);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= 16'h0000;
    end else if (clk_en) begin
      remain <= next_remain;
    end
  end

  assign busy = (remain != 16'h0000);

  chk_jam_counts_down: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !start && remain > 16'h0001 |=> remain == $past(remain) - 16'h0001)
    else $error("jam timer did not count down");
endmodule // eafc_jam_timer

// File: verification/eafc_mac_model.sv
// MAC transmit side model that queues and acknowledges pause requests.
// Assumes pause_req is a level held until acknowledged, all on core_clk.
`timescale 1ns/1ps
module eafc_mac_model
  import eafc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        pause_req,
  input  wire logic [15:0] pause_time,
  input  wire logic [3:0]  ack_delay,
  output logic             pause_ack,
  output logic [7:0]       pause_cnt,
  output logic [15:0]      last_time
);
  logic [3:0] wait_cnt;
  // Waits for the next transmit window, then takes the frame once.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      pause_ack <= 1'b0;
      pause_cnt <= 8'h00;
      last_time <= 16'h0000;
    end else if (pause_ack) begin
      pause_ack <= 1'b0;
    end else if (pause_req && wait_cnt >= ack_delay) begin
      pause_ack <= 1'b1;
      wait_cnt <= 4'h0;
      pause_cnt <= pause_cnt + 8'h01;
      last_time <= pause_time;
    end else if (pause_req) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // eafc_mac_model

// File: verification/eafc_top_test.sv
// Self-checking bench for the automatic flow control block.
// Assumes the MAC model answers pause requests; receive events come from here.
`timescale 1ns/1ps
module eafc_top_test
  import eafc_pkg::*;
;
  logic core_clk, rst_n, reg_wr, reg_rd, full_duplex, speed_10m, tx_enabled;
  logic pause_req, pause_ack, jam_active, clk_en;
  logic [7:0] reg_addr, pause_cnt;
  logic [31:0] reg_wdata, reg_rdata;
  logic [EAFC_FIFO_W:0] rx_fifo_bytes;
  logic [15:0] pause_time, last_time;
  eafc_rxev_s rx_ev;
  int errors, check_count;
  int cycles = 0;
  eafc_top i_eafc_top (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rx_fifo_bytes(rx_fifo_bytes), .full_duplex(full_duplex),
    .speed_10m(speed_10m), .tx_enabled(tx_enabled), .rx_ev(rx_ev),
    .pause_time_value(16'h1234), .pause_req(pause_req), .pause_time(pause_time),
    .pause_ack(pause_ack), .jam_active(jam_active));
  eafc_mac_model i_eafc_mac_model (.core_clk(core_clk), .rst_n(rst_n),
    .pause_req(pause_req), .pause_time(pause_time), .ack_delay(4'h5),
    .pause_ack(pause_ack), .pause_cnt(pause_cnt), .last_time(last_time));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  task automatic settle(input logic [EAFC_FIFO_W:0] b);
    @(posedge core_clk);
    rx_fifo_bytes <= b;
    repeat (40) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    rd(EAFC_CFG_OFFSET, d);
    chk("cfg reset", 32'h0, d);
    wr(EAFC_CFG_OFFSET, 32'hffffffff);
    rd(EAFC_CFG_OFFSET, d);
    chk("cfg readback", 32'h00ffffff, d);
    wr(8'ha8, 32'h0);
    rd(EAFC_CFG_OFFSET, d);
    chk("cfg after other write", 32'h00ffffff, d);
    rd(8'ha8, d);
    chk("other read", 32'h0, d);
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(EAFC_CFG_OFFSET, 32'h0);
    clk_en <= 1'b1;
    rd(EAFC_CFG_OFFSET, d);
    chk("cfg frozen write", 32'h00ffffff, d);
  endtask
  task automatic t_full();
    wr(EAFC_CFG_OFFSET, 32'h00020101);
    settle(15'd127);
    chk("pause below high", 32'h0, {24'h0, pause_cnt});
    settle(15'd128);
    chk("timed pause count", 32'h1, {24'h0, pause_cnt});
    chk("timed pause value", 32'h1234, {16'h0, last_time});
    settle(15'd64);
    chk("pause at low", 32'h1, {24'h0, pause_cnt});
    settle(15'd63);
    chk("zero pause count", 32'h2, {24'h0, pause_cnt});
    chk("zero pause value", 32'h0, {16'h0, last_time});
  endtask
  task automatic t_jam(input logic [31:0] cfg, input logic fd, input logic slow,
                       input eafc_rxev_s ev, input logic [31:0] exp);
    logic [31:0] n;
    n = 32'h0;
    wr(EAFC_CFG_OFFSET, cfg);
    @(posedge core_clk);
    full_duplex <= fd;
    speed_10m <= slow;
    rx_fifo_bytes <= 15'd64;
    @(posedge core_clk);
    rx_ev <= ev;
    @(posedge core_clk);
    rx_ev <= '0;
    repeat (700) begin
      @(negedge core_clk);
      if (jam_active === 1'b1) n++;
    end
    chk("jam cycles", exp, n);
    settle(15'd0);
  endtask
  task automatic t_txoff();
    @(posedge core_clk);
    tx_enabled <= 1'b0;
    settle(15'd200);
    chk("pause with tx off", 32'h2, {24'h0, pause_cnt});
    t_jam(32'h00010008, 1'b0, 1'b0, 5'b10100, 32'd0);
    tx_enabled <= 1'b1;
  endtask
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    full_duplex = 1'b1;
    speed_10m = 1'b0;
    tx_enabled = 1'b1;
    clk_en = 1'b1;
    rx_fifo_bytes = '0;
    rx_ev = '0;
    errors = 0;
    check_count = 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_full();
    t_txoff();
    t_jam(32'h00010008, 1'b0, 1'b0, 5'b10100, 32'd250);
    t_jam(32'h00010004, 1'b0, 1'b1, 5'b10010, 32'd360);
    t_jam(32'h00010002, 1'b0, 1'b0, 5'b10001, 32'd250);
    t_jam(32'h00010001, 1'b0, 1'b0, 5'b01000, 32'd250);
    t_jam(32'h00010018, 1'b0, 1'b0, 5'b10100, 32'd500);
    t_jam(32'h00010008, 1'b0, 1'b0, 5'b10010, 32'd0);
    t_jam(32'h00020008, 1'b0, 1'b0, 5'b10100, 32'd0);
    t_jam(32'h00010008, 1'b1, 1'b0, 5'b10100, 32'd0);
    summarize();
  end
endmodule // eafc_top_test
